// [lifd_pkg.sv]
// Purpose: Shared constants and types for the logical, integer and float datapath
// Assumes: 64-bit words, one CPU clock
// Notes:   Exponent figures are the octal values converted to hex
package lifd_pkg;

  localparam int W_WORD = 64;
  localparam int W_COEF = 48;
  localparam int W_EXP  = 15;

  // Field positions of a float word
  localparam int SIGN_BIT = 63;
  localparam int EXP_HI   = 62;
  localparam int EXP_LO   = 48;
  localparam int EXP_SGN  = 61;
  localparam int COEF_MSB = 47;

  // Exponent constants (bias 40000 octal, overflow 60000 octal)
  localparam logic [14:0]        EXP_BIAS  = 15'h4000;
  localparam logic [14:0]        EXP_OVF   = 15'h6000;
  localparam logic [14:0]        EXP_INT48 = 15'h4030;
  localparam logic [14:0]        EXP_TWO   = 15'h0002;
  localparam logic signed [17:0] E_OVF_MIN = 18'sh0_6000;
  localparam logic signed [17:0] E_UNF_MAX = 18'sh0_1FFF;
  localparam logic [63:0]        NEG_ZERO  = 64'h8000_0000_0000_0000;

  // Address widths per mode, and host operand pre-shifts
  localparam int W_ADDR_N = 24;
  localparam int W_ADDR_W = 32;
  localparam int INT24_LO = 24;
  localparam int SH_SCAL  = 31;
  localparam int SH_VECT  = 16;

  typedef enum logic [3:0] {
    OP_AND   = 4'h0,
    OP_OR    = 4'h1,
    OP_XOR   = 4'h2,
    OP_XNOR  = 4'h3,
    OP_MERGE = 4'h4,
    OP_AADD  = 4'h5,
    OP_ASUB  = 4'h6,
    OP_AMUL  = 4'h7,
    OP_SADD  = 4'h8,
    OP_SSUB  = 4'h9,
    OP_FADD  = 4'hA,
    OP_FSUB  = 4'hB,
    OP_FMUL  = 4'hC,
    OP_FRCP  = 4'hD,
    OP_IMUL32 = 4'hE
  } lifd_op_t;

  // Host request kinds: plain op, or an integer job the host prepares
  typedef enum logic [1:0] {
    KD_OP       = 2'h0,
    KD_INT24MUL = 2'h1,
    KD_SVMUL32  = 2'h2,
    KD_NORM_INT = 2'h3
  } lifd_kind_t;

endpackage

// [lifd_if.sv]
// Purpose: Link between instruction issue and the datapath
// Assumes: Same clock on both ends, fixed one-cycle datapath latency
// Notes:   No back-pressure; the unit accepts one operand set every clock
`timescale 1ns/1ps
interface lifd_if;
  import lifd_pkg::*;
  logic        req_valid;
  lifd_op_t    req_op;
  logic        req_wide;
  logic [63:0] req_a;
  logic [63:0] req_b;
  logic [63:0] req_mask;
  logic        rsp_valid;
  logic [63:0] rsp_data;
  logic        rsp_fp_err;

  modport dev (
    input  req_valid, req_op, req_wide, req_a, req_b, req_mask,
    output rsp_valid, rsp_data, rsp_fp_err
  );
  modport iss (
    output req_valid, req_op, req_wide, req_a, req_b, req_mask,
    input  rsp_valid, rsp_data, rsp_fp_err
  );
endinterface

// [lifd_unit.sv]
// Purpose: Logical, integer and floating-point datapath, one result per clock
// Assumes: Operands arrive from the issue end on the same clock
// Notes:   Float add, multiply and reciprocal are simplified but keep the word format
// Notes on behaviour
// - Logical results are strictly bitwise on 64 bits
// - AND, OR, XOR and XNOR logical functions
// - Merge takes operand 1 where mask is one
// - Integer arithmetic uses two's complement
// - Address add/multiply: 24 bits narrow, 32 wide
// - Scalar add uses full 64 bits
// - Zero exponents: integer product, no normalize, no range
// - Integer product complete up to 48 bit positions
// - Host puts 24-bit integers in coefficient bits 47..24
// - Integer result is upper 48 product bits, exponent zero
// - Integer product sign is XOR of signs
// - Host converts negative sign-magnitude products to two's complement
// - 32-bit multiply: shifts 31 and 16, result bits 31..0
// - Reciprocal assumes coefficient msb one, checks overflow only
// - Sign bit 63, biased exponent 62..48, 48-bit coefficient
// - Exponent bit 61 is sign, bit 62 bias
// - Normalized means coefficient bit 47 set
// - Zero or underflow gives all-zero word
// - Negative zero only from a negative zero operand
// - Host normalizes 40060-exponent integers by adding zero
// - Overflow keeps coefficient (reciprocal clears bit 47), exponent 60000, sets error
// - Underflow zeroes the word, no error
`timescale 1ns/1ps
module lifd_unit import lifd_pkg::*; (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Issue link
  lifd_if.dev       link,
  // Status
  output logic      o_fp_err
);

  logic [63:0]  a;
  logic [63:0]  b;
  logic [63:0]  res_nxt;
  logic         err_nxt;
  logic [95:0]  prod;
  logic [63:0]  imul32;
  logic [63:0]  rsp_data_r;
  logic         rsp_valid_r;
  logic         fp_err_r;

  assign a = link.req_a;
  assign b = link.req_b;

  // One shared 48x48 multiplier serves integer and float cases
  assign prod   = a[47:0] * b[47:0];
  assign imul32 = {32'h0000_0000, 32'(a[62:31] * b[47:16])};

  function automatic logic [5:0] lzc48(input logic [47:0] v);
    logic [5:0] n;
    logic       f;
    n = 6'd48;
    f = 1'b0;
    for (int i = 47; i >= 0; i--) begin
      if (!f && v[i]) begin
        n = 6'(47 - i);
        f = 1'b1;
      end
    end
    return n;
  endfunction

  // Range check and packing: returns {error, word}
  function automatic logic [64:0] fp_pack(input logic s, input logic signed [17:0] e,
                                          input logic [47:0] c);
    if (c == 48'h0 || e <= E_UNF_MAX) begin
      return 65'h0;
    end else if (e >= E_OVF_MIN) begin
      return {1'b1, s, EXP_OVF, c};
    end else begin
      return {1'b0, s, e[14:0], c};
    end
  endfunction

  // Float add and subtract with full renormalization
  function automatic logic [64:0] fp_add(input logic [63:0] x, input logic [63:0] y,
                                         input logic sub);
    logic        sx, sy, sbig, ssml;
    logic [14:0] ebig;
    logic [15:0] diff;
    logic [47:0] cbig, csml;
    logic [48:0] sum;
    logic [5:0]  lz;
    logic signed [17:0] e;
    logic [47:0] c;
    logic        s;
    sx = x[SIGN_BIT];
    sy = y[SIGN_BIT] ^ sub;
    if (x[EXP_HI:EXP_LO] >= y[EXP_HI:EXP_LO]) begin
      ebig = x[EXP_HI:EXP_LO];
      diff = {1'b0, x[EXP_HI:EXP_LO]} - {1'b0, y[EXP_HI:EXP_LO]};
      cbig = x[47:0];
      csml = y[47:0];
      sbig = sx;
      ssml = sy;
    end else begin
      ebig = y[EXP_HI:EXP_LO];
      diff = {1'b0, y[EXP_HI:EXP_LO]} - {1'b0, x[EXP_HI:EXP_LO]};
      cbig = y[47:0];
      csml = x[47:0];
      sbig = sy;
      ssml = sx;
    end
    // Shifted-out bits are lost, no round up
    csml = (diff > 16'd47) ? 48'h0 : (csml >> diff);
    if (sbig == ssml) begin
      sum = {1'b0, cbig} + {1'b0, csml};
      s   = sbig;
    end else if (cbig >= csml) begin
      sum = {1'b0, cbig - csml};
      s   = sbig;
    end else begin
      sum = {1'b0, csml - cbig};
      s   = ssml;
    end
    e  = 18'($signed({3'b000, ebig}));
    lz = lzc48(sum[47:0]);
    if (sum[48]) begin
      c = sum[48:1];
      e = e + 18'sd1;
    end else begin
      c = sum[47:0] << lz;
      e = e - 18'($signed({12'h000, lz}));
    end
    return fp_pack(s, e, c);
  endfunction

  // Float multiply; zero exponents select the integer case
  function automatic logic [64:0] fp_mul(input logic [63:0] x, input logic [63:0] y,
                                         input logic [95:0] p);
    logic               s;
    logic signed [17:0] e;
    s = x[SIGN_BIT] ^ y[SIGN_BIT];
    if (x[EXP_HI:EXP_LO] == 15'h0 && y[EXP_HI:EXP_LO] == 15'h0) begin
      return {1'b0, s, 15'h0, p[95:48]};
    end
    e = 18'($signed({3'b000, x[EXP_HI:EXP_LO]})) + 18'($signed({3'b000, y[EXP_HI:EXP_LO]}))
        - 18'($signed({3'b000, EXP_BIAS}));
    if (p[95]) begin
      return fp_pack(s, e, p[95:48]);
    end else begin
      return fp_pack(s, e - 18'sd1, p[94:47]);
    end
  endfunction

  // Reciprocal estimate: msb never tested, assumed one
  function automatic logic [64:0] fp_rcp(input logic [63:0] x);
    logic [14:0] e;
    logic [47:0] c;
    e = 15'(~x[EXP_HI:EXP_LO] + EXP_TWO);
    c = {1'b1, ~x[46:0]};
    if (e[14:13] == 2'b11) begin
      return {1'b1, x[SIGN_BIT], EXP_OVF, 1'b0, c[46:0]};
    end
    return {1'b0, x[SIGN_BIT], e, c};
  endfunction

  always_comb begin
    logic [64:0] f;
    logic [31:0] am;
    logic [31:0] amsk;
    f       = 65'h0;
    am      = 32'h0;
    amsk    = link.req_wide ? 32'hFFFF_FFFF : 32'h00FF_FFFF;
    err_nxt = 1'b0;
    res_nxt = 64'h0;
    case (link.req_op)
      OP_AND:   res_nxt = a & b;
      OP_OR:    res_nxt = a | b;
      OP_XOR:   res_nxt = a ^ b;
      OP_XNOR:  res_nxt = ~(a ^ b);
      OP_MERGE: res_nxt = (a & link.req_mask) | (b & ~link.req_mask);
      OP_AADD: begin
        am      = (a[31:0] + b[31:0]) & amsk;
        res_nxt = {32'h0000_0000, am};
      end
      OP_ASUB: begin
        am      = (a[31:0] - b[31:0]) & amsk;
        res_nxt = {32'h0000_0000, am};
      end
      OP_AMUL: begin
        am      = 32'(a[31:0] * b[31:0]) & amsk;
        res_nxt = {32'h0000_0000, am};
      end
      OP_SADD:  res_nxt = a + b;
      OP_SSUB:  res_nxt = a - b;
      OP_FADD, OP_FSUB: begin
        f = fp_add(a, b, link.req_op == OP_FSUB);
        // Only a negative zero operand can yield negative zero
        if (f[63:0] == 64'h0 && (a == NEG_ZERO || b == NEG_ZERO)) begin
          f[63:0] = NEG_ZERO;
        end
        res_nxt = f[63:0];
        err_nxt = f[64];
      end
      OP_FMUL: begin
        f = fp_mul(a, b, prod);
        if (f[62:0] == 63'h0 && !(a == NEG_ZERO || b == NEG_ZERO)) begin
          f[63] = 1'b0;
        end
        res_nxt = f[63:0];
        err_nxt = f[64];
      end
      OP_FRCP: begin
        f       = fp_rcp(a);
        res_nxt = f[63:0];
        err_nxt = f[64];
      end
      OP_IMUL32: res_nxt = imul32;
      default:   res_nxt = 64'h0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= link.req_valid;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rsp_data_r <= 64'h0;
      fp_err_r   <= 1'b0;
    end else if (link.req_valid) begin
      rsp_data_r <= res_nxt;
      fp_err_r   <= err_nxt;
    end else begin
      fp_err_r   <= 1'b0;
    end
  end

  assign link.rsp_valid  = rsp_valid_r;
  assign link.rsp_data   = rsp_data_r;
  assign link.rsp_fp_err = fp_err_r;
  assign o_fp_err        = fp_err_r;

endmodule // lifd_unit

// [lifd_issue.sv]
// Purpose: Issue end: prepares integer jobs and fixes up 24-bit multiply results
// Assumes: Datapath answers exactly one clock after a request
// Notes:   Fully pipelined; three clocks from user request to result
`timescale 1ns/1ps
module lifd_issue import lifd_pkg::*; (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // User request
  input  wire logic        i_valid,
  input  wire lifd_kind_t  i_kind,
  input  wire lifd_op_t    i_op,
  input  wire logic        i_wide,
  input  wire logic [63:0] i_a,
  input  wire logic [63:0] i_b,
  input  wire logic [63:0] i_mask,
  // User result
  output logic             o_valid,
  output logic [63:0]      o_result,
  output logic             o_fp_err,
  // Datapath link
  lifd_if.iss              link
);

  logic        valid_r;
  lifd_op_t    op_r;
  logic        wide_r;
  logic [63:0] a_r;
  logic [63:0] b_r;
  logic [63:0] mask_r;
  lifd_kind_t  kind_r;
  lifd_kind_t  kind_d_r;
  logic        o_valid_r;
  logic [63:0] o_result_r;
  logic        o_fp_err_r;
  logic [23:0] mag_a;
  logic [23:0] mag_b;

  // Sign-magnitude split of 24-bit two's complement inputs
  assign mag_a = i_a[23] ? 24'(-i_a[23:0]) : i_a[23:0];
  assign mag_b = i_b[23] ? 24'(-i_b[23:0]) : i_b[23:0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      valid_r  <= 1'b0;
      kind_r   <= KD_OP;
      kind_d_r <= KD_OP;
    end else begin
      valid_r  <= i_valid;
      kind_r   <= i_kind;
      kind_d_r <= kind_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      op_r   <= OP_AND;
      wide_r <= 1'b0;
      a_r    <= 64'h0;
      b_r    <= 64'h0;
      mask_r <= 64'h0;
    end else if (i_valid) begin
      wide_r <= i_wide;
      mask_r <= i_mask;
      case (i_kind)
        KD_INT24MUL: begin
          op_r <= OP_FMUL;
          a_r  <= {i_a[23], 15'h0, mag_a, 24'h00_0000};
          b_r  <= {i_b[23], 15'h0, mag_b, 24'h00_0000};
        end
        KD_SVMUL32: begin
          op_r <= OP_IMUL32;
          a_r  <= {32'h0, i_a[31:0]} << SH_SCAL;
          b_r  <= {32'h0, i_b[31:0]} << SH_VECT;
        end
        KD_NORM_INT: begin
          op_r <= OP_FADD;
          a_r  <= {1'b0, EXP_INT48, i_a[47:0]};
          b_r  <= 64'h0;
        end
        default: begin
          op_r <= i_op;
          a_r  <= i_a;
          b_r  <= i_b;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_valid_r  <= 1'b0;
      o_result_r <= 64'h0;
      o_fp_err_r <= 1'b0;
    end else begin
      o_valid_r  <= link.rsp_valid;
      o_fp_err_r <= link.rsp_valid & link.rsp_fp_err;
      if (link.rsp_valid) begin
        if (kind_d_r == KD_INT24MUL && link.rsp_data[SIGN_BIT]) begin
          o_result_r <= 64'(-{16'h0000, link.rsp_data[47:0]});
        end else if (kind_d_r == KD_INT24MUL) begin
          o_result_r <= {16'h0000, link.rsp_data[47:0]};
        end else begin
          o_result_r <= link.rsp_data;
        end
      end
    end
  end

  assign link.req_valid = valid_r;
  assign link.req_op    = op_r;
  assign link.req_wide  = wide_r;
  assign link.req_a     = a_r;
  assign link.req_b     = b_r;
  assign link.req_mask  = mask_r;
  assign o_valid        = o_valid_r;
  assign o_result       = o_result_r;
  assign o_fp_err       = o_fp_err_r;

endmodule // lifd_issue

// [lifd_checker.sv]
// Purpose: Assertions on the issue-to-datapath link
// Assumes: One clock, sync active-high reset, one-cycle datapath answer
// Notes:   Watches the interface only; user side is judged by the bench
`timescale 1ns/1ps
module lifd_checker import lifd_pkg::*; (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_srst,
  // Link signals
  input wire logic        req_valid,
  input wire lifd_op_t    req_op,
  input wire logic        req_wide,
  input wire logic [63:0] req_a,
  input wire logic [63:0] req_b,
  input wire logic [63:0] req_mask,
  input wire logic        rsp_valid,
  input wire logic [63:0] rsp_data,
  input wire logic        rsp_fp_err
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  logic [95:0] prod_r;
  logic        sgn_r;
  logic        nz_r;
  logic        int_case;
  assign int_case = req_valid && req_op == OP_FMUL && req_a[62:48] == 15'h0000 && req_b[62:48] == 15'h0000;
  // Full product kept so truncation in the unit would show
  always_ff @(posedge i_clk) begin
    prod_r <= req_a[47:0] * req_b[47:0];
    sgn_r  <= req_a[63] ^ req_b[63];
    nz_r   <= req_a == NEG_ZERO || req_b == NEG_ZERO;
  end

  a_rsp_one_late: assert property (req_valid |=> rsp_valid)
    else $error("answer not one cycle after request");
  a_xnor_result: assert property (req_valid && req_op == OP_XNOR |=> rsp_data == ~($past(req_a) ^ $past(req_b)))
    else $error("equivalence result wrong");
  a_merge_pick: assert property (req_valid && req_op == OP_MERGE |=>
    rsp_data == (($past(req_a) & $past(req_mask)) | ($past(req_b) & ~$past(req_mask))))
    else $error("merge result wrong");
  a_addr_width: assert property (req_valid && req_op == OP_AADD |=>
    rsp_data == ($past(req_a) + $past(req_b) & ($past(req_wide) ? 64'h0000_0000_FFFF_FFFF : 64'h0000_0000_00FF_FFFF)))
    else $error("address add width wrong");
  a_scalar_add: assert property (req_valid && req_op == OP_SADD |=> rsp_data == $past(req_a) + $past(req_b))
    else $error("scalar add wrong");
  // A zero product keeps its sign only when an operand was negative zero
  a_int_product: assert property (int_case |=>
    rsp_data == {sgn_r && (prod_r[95:48] != 48'h0 || nz_r), 15'h0000, prod_r[95:48]} && !rsp_fp_err)
    else $error("integer product wrong");
  a_ovf_exp: assert property (rsp_fp_err |-> rsp_valid && rsp_data[62:48] == EXP_OVF)
    else $error("overflow exponent wrong");
  a_unf_zero: assert property (req_valid && req_op == OP_FADD |=>
    rsp_data[62:61] != 2'b00 || rsp_data[62:0] == 63'h0)
    else $error("underflow not zeroed");
  a_no_negzero: assert property (rsp_valid && rsp_data == NEG_ZERO &&
    $past(req_op) inside {OP_FADD, OP_FSUB} |-> $past(req_a) == NEG_ZERO || $past(req_b) == NEG_ZERO)
    else $error("negative zero produced");
endmodule // lifd_checker

// [testbench.sv]
// Purpose: Self-checking bench, issue end joined to the datapath
// Assumes: Results come back in order, three clocks after a request
// Notes:   Expectations queue up so back-to-back requests are exercised
`timescale 1ns/1ps
module testbench;
  import lifd_pkg::*;
  logic        i_clk = 0;
  logic        i_srst = 1;
  logic        i_valid = 0;
  lifd_kind_t  i_kind = KD_OP;
  lifd_op_t    i_op = OP_AND;
  logic        i_wide = 0;
  logic [63:0] i_a = 0, i_b = 0, i_mask = 0;
  logic        o_valid, o_fp_err, unit_fp_err;
  logic [63:0] o_result;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  logic [63:0] exp_q[$];
  logic        err_q[$];

  lifd_if link_if();
  lifd_unit u_lifd_unit(.i_clk(i_clk), .i_srst(i_srst), .link(link_if.dev), .o_fp_err(unit_fp_err));
  lifd_issue u_lifd_issue(.i_clk(i_clk), .i_srst(i_srst), .i_valid(i_valid), .i_kind(i_kind), .i_op(i_op),
    .i_wide(i_wide), .i_a(i_a), .i_b(i_b), .i_mask(i_mask), .o_valid(o_valid), .o_result(o_result),
    .o_fp_err(o_fp_err), .link(link_if.iss));
  lifd_checker u_lifd_checker(.i_clk(i_clk), .i_srst(i_srst), .req_valid(link_if.req_valid),
    .req_op(link_if.req_op), .req_wide(link_if.req_wide), .req_a(link_if.req_a), .req_b(link_if.req_b),
    .req_mask(link_if.req_mask), .rsp_valid(link_if.rsp_valid), .rsp_data(link_if.rsp_data),
    .rsp_fp_err(link_if.rsp_fp_err));

  always #2 i_clk = ~i_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard; the whole run needs well under 300 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Outputs stand a whole cycle, so the falling edge sees them settled
  always @(negedge i_clk) begin
    if (o_valid !== 1'b0) begin
      if (exp_q.size() == 0) check({63'h0, o_valid}, 64'h0);
      else begin
        check(o_result, exp_q.pop_front());
        check({63'h0, o_fp_err}, {63'h0, err_q.pop_front()});
      end
    end
    // Unit flag leads the issue copy by one cycle; queue head is the item on the link
    if (link_if.rsp_valid === 1'b1 && err_q.size() > 0) check({63'h0, unit_fp_err}, {63'h0, err_q[0]});
    else check({63'h0, unit_fp_err}, 64'h0);
  end

  task automatic send(input lifd_kind_t k, input lifd_op_t op, input logic w, input logic [63:0] a,
                      input logic [63:0] b, input logic [63:0] m, input logic [63:0] e, input logic er);
    @(negedge i_clk);
    i_valid = 1;
    i_kind = k;
    i_op = op;
    i_wide = w;
    i_a = a;
    i_b = b;
    i_mask = m;
    exp_q.push_back(e);
    err_q.push_back(er);
  endtask

  task automatic drain(input string name);
    @(negedge i_clk);
    i_valid = 0;
    repeat (6) @(negedge i_clk);
    check(exp_q.size(), 64'h0);
    $display("test %s done", name);
  endtask

  localparam logic [63:0] PA = 64'hF0F0_AAAA_1234_5678;
  localparam logic [63:0] PB = 64'hFF00_CCCC_8765_4321;
  localparam logic [63:0] PM = 64'h00FF_F0F0_FFFF_0000;

  task automatic t_logic();
    send(KD_OP, OP_AND, 0, PA, PB, PM, PA & PB, 0);
    send(KD_OP, OP_OR, 0, PA, PB, PM, PA | PB, 0);
    send(KD_OP, OP_XOR, 0, PA, PB, PM, PA ^ PB, 0);
    send(KD_OP, OP_XNOR, 0, PA, PB, PM, ~(PA ^ PB), 0);
    send(KD_OP, OP_MERGE, 0, PA, PB, PM, (PA & PM) | (PB & ~PM), 0);
    drain("logic");
  endtask

  task automatic t_int_add();
    send(KD_OP, OP_AADD, 0, 64'h0000_0000_00FF_FFFF, 64'h1, 0, 64'h0, 0);
    send(KD_OP, OP_AADD, 1, 64'h0000_0000_00FF_FFFF, 64'h1, 0, 64'h0000_0000_0100_0000, 0);
    send(KD_OP, OP_ASUB, 0, 64'h0, 64'h1, 0, 64'h0000_0000_00FF_FFFF, 0);
    send(KD_OP, OP_ASUB, 1, 64'h0, 64'h1, 0, 64'h0000_0000_FFFF_FFFF, 0);
    send(KD_OP, OP_AMUL, 0, 64'h1000, 64'h1000, 0, 64'h0, 0);
    send(KD_OP, OP_AMUL, 1, 64'h1000, 64'h1000, 0, 64'h0000_0000_0100_0000, 0);
    send(KD_OP, OP_SADD, 0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 0, 64'h0, 0);
    send(KD_OP, OP_SSUB, 0, 64'h0, 64'h1, 0, 64'hFFFF_FFFF_FFFF_FFFF, 0);
    drain("integer add");
  endtask

  task automatic t_int_mul();
    send(KD_INT24MUL, OP_FMUL, 0, 64'h4, 64'h6, 0, 64'h18, 0);
    send(KD_INT24MUL, OP_FMUL, 0, 64'h0000_0000_00FF_FFFD, 64'h5, 0, 64'hFFFF_FFFF_FFFF_FFF1, 0);
    send(KD_OP, OP_FMUL, 0, 64'h8000_0000_0400_0000, 64'h0000_0000_0600_0000, 0, 64'h8000_0000_0000_0018, 0);
    send(KD_SVMUL32, OP_FMUL, 0, 64'h0001_0000, 64'h0001_0003, 0, 64'h0003_0000, 0);
    send(KD_SVMUL32, OP_FMUL, 0, 64'hFFFF_FFFF, 64'h2, 0, 64'hFFFF_FFFE, 0);
    drain("integer multiply");
  endtask

  task automatic t_float();
    send(KD_OP, OP_FMUL, 0, 64'h4001_8000_0000_0000, 64'h4001_8000_0000_0000, 0, 64'h4001_8000_0000_0000, 0);
    send(KD_OP, OP_FMUL, 0, 64'hC001_8000_0000_0000, 64'h3FFF_8000_0000_0000, 0, 64'hBFFF_8000_0000_0000, 0);
    send(KD_OP, OP_FMUL, 0, 64'h5001_8000_0000_0000, 64'h5001_C000_0000_0000, 0, 64'h6000_C000_0000_0000, 1);
    send(KD_OP, OP_FMUL, 0, 64'h2000_8000_0000_0000, 64'h2000_8000_0000_0000, 0, 64'h0, 0);
    send(KD_NORM_INT, OP_FADD, 0, 64'h1, 64'h0, 0, 64'h4001_8000_0000_0000, 0);
    send(KD_OP, OP_FSUB, 0, 64'h4001_8000_0000_0000, 64'h4001_8000_0000_0000, 0, 64'h0, 0);
    send(KD_OP, OP_FADD, 0, NEG_ZERO, NEG_ZERO, 0, NEG_ZERO, 0);
    send(KD_OP, OP_FADD, 0, 64'h2000_C000_0000_0000, 64'hA000_8000_0000_0000, 0, 64'h0, 0);
    send(KD_OP, OP_FADD, 0, 64'h5FFF_8000_0000_0000, 64'h5FFF_8000_0000_0000, 0, 64'h6000_8000_0000_0000, 1);
    send(KD_OP, OP_FRCP, 0, 64'h2000_8000_0000_0000, 64'h0, 0, 64'h6000_7FFF_FFFF_FFFF, 1);
    send(KD_OP, OP_FRCP, 0, 64'h2000_0000_0000_0000, 64'h0, 0, 64'h6000_7FFF_FFFF_FFFF, 1);
    drain("float");
  endtask

  initial begin
    repeat (2) @(negedge i_clk);
    i_srst = 0;
    t_logic();
    t_int_add();
    t_int_mul();
    t_float();
    stop_test();
  end
endmodule // testbench
